//--- uart_fifo_consts.svh
// Constants for the UART FIFO control and DMA ready block.
// Function
// - Bits 7:6 pick threshold 1, 4, 8, 14.
// - Receive condition raised when count reaches threshold.
// - Receive queue keeps filling until completely full.
// - Bits 5:4 unused, always held at zero.
// - Bit 3 selects ready mode 0 or 1.
// - Mode 0: transmit ready low when nothing queued.
// - Mode 0: transmit ready high after first write; code holds it high only while the transmit queue holds a byte behind the stage.
// - Mode 0: receive ready low while characters held.
// - Mode 1: transmit ready high only when full.
// - Mode 1: receive ready low on threshold/timeout.
// - Bit 2 flushes transmit queue, then self-clears.
// - Bit 1 flushes receive queue, then self-clears.
// - Bit 0 enables both queues, else single buffer.
// - Write with bit 0 clear changes nothing else.
// - Reset clears trigger, flush and enable bits.
// - Source bits 7:6 show queue enable state.
// - Receive condition withdrawn below the threshold.
`ifndef UART_FIFO_CONSTS_SVH
`define UART_FIFO_CONSTS_SVH
`define CHANNELS 2
`define QUEUE_DEPTH 5'h10
`define SINGLE_DEPTH 5'h01
`define TRIG_1 5'h01
`define TRIG_4 5'h04
`define TRIG_8 5'h08
`define TRIG_14 5'h0e
`define REG_DATA 3'h0
`define REG_SETUP 3'h1
`define REG_SOURCE 3'h2
`define REG_STATUS 3'h3
`define REG_MASK 3'h4
`define SETUP_RESET 8'h00
`define SETUP_KEEP 8'hcf
`define BIT_EN 0
`define BIT_RX_FLUSH 1
`define BIT_TX_FLUSH 2
`define BIT_MODE 3
`define TRIG_HI 7
`define TRIG_LO 6
`define EV_RX_LEVEL 0
`define EV_TX_EMPTY 1
`define EV_RX_TMO 2
`define SRC_NONE 4'h1
`define SRC_RX 4'h4
`define SRC_RX_TMO 4'hc
`define SRC_TX 4'h2
`endif

//--- uart_fifo_pkg.sv
// Types shared by the UART FIFO control and DMA ready block.
package uart_fifo_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;
  typedef struct packed {
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_timeout;
    logic tx_load;
  } shift_in_type;
  typedef struct packed {
    logic tx_valid;
    logic [7:0] tx_data;
  } shift_out_type;
  typedef struct packed {
    logic [15:0][7:0] mem;
    logic [3:0] wptr;
    logic [3:0] rptr;
    logic [4:0] count;
  } queue_state_type;
  typedef struct packed {
    logic [7:0] setup;
    logic stage_valid;
    logic [7:0] stage_data;
    logic tx_req_n;
    logic rx_req_n;
    logic [2:0] status;
    logic [2:0] mask;
    logic rx_level;
    logic tx_empty;
  } chan_type;
  typedef struct packed {
    chan_type [1:0] ch;
    logic [7:0] rdata;
    logic irq;
  } top_state_type;
endpackage

//--- fifo_queue.sv
// Sixteen-entry byte queue with flush and a run-time fill limit.
`timescale 1ns/1ps
`include "uart_fifo_consts.svh"
module fifo_queue (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic flush_in,
  input wire logic [4:0] limit_in,
  input wire logic push_in,
  input wire logic [7:0] data_in,
  input wire logic pop_in,
  output logic [7:0] data_out,
  output logic [4:0] count_out,
  output logic full_out,
  output logic empty_out
);
  uart_fifo_pkg::queue_state_type s_q;
  uart_fifo_pkg::queue_state_type s_d;
  logic push_ok;
  logic pop_ok;

  always_comb
  begin
    s_d = s_q;
    push_ok = push_in && (s_q.count < limit_in);
    pop_ok = pop_in && (s_q.count != 5'h00);
    if (flush_in)
    begin
      // Pointers and count reset; stored bytes become unreachable.
      s_d.wptr = 4'h0;
      s_d.rptr = 4'h0;
      s_d.count = 5'h00;
    end
    else
    begin
      if (push_ok)
      begin
        s_d.mem[s_q.wptr] = data_in;
        s_d.wptr = s_q.wptr + 4'h1;
      end
      if (pop_ok)
      begin
        s_d.rptr = s_q.rptr + 4'h1;
      end
      s_d.count = s_q.count + {4'h0, push_ok} - {4'h0, pop_ok};
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign data_out = s_q.mem[s_q.rptr];
  assign count_out = s_q.count;
  assign full_out = s_q.count >= limit_in;
  assign empty_out = s_q.count == 5'h00;
endmodule // fifo_queue

//--- uart_fifo_control_dma_ready.sv
// Two-channel UART FIFO control, DMA ready outputs and interrupt status.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "uart_fifo_consts.svh"
module uart_fifo_control_dma_ready (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire uart_fifo_pkg::bus_req_type bus_in,
  output logic [7:0] rdata_out,
  input wire uart_fifo_pkg::shift_in_type [1:0] shift_in,
  output uart_fifo_pkg::shift_out_type [1:0] shift_out,
  output logic [1:0] tx_dma_request_n_out,
  output logic [1:0] rx_dma_request_n_out,
  output logic irq_out
);
  uart_fifo_pkg::top_state_type s_q;
  uart_fifo_pkg::top_state_type s_d;

  logic [1:0] tx_push;
  logic [1:0] tx_pop;
  logic [1:0] tx_flush;
  logic [1:0] tx_full;
  logic [1:0] tx_empty;
  logic [1:0][7:0] tx_head;
  logic [1:0][4:0] tx_count;
  logic [1:0] rx_push;
  logic [1:0] rx_pop;
  logic [1:0] rx_flush;
  logic [1:0] rx_full;
  logic [1:0] rx_empty;
  logic [1:0][7:0] rx_head;
  logic [1:0][4:0] rx_count;
  logic [1:0][4:0] limit;
  logic [1:0][4:0] trig;
  logic [1:0] rx_level;
  logic [1:0] wr_setup;

  function automatic logic hit(input logic [3:0] a, input int c, input logic [2:0] idx);
    return a == {c[0], idx};
  endfunction

  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'b00: return `TRIG_1;
      2'b01: return `TRIG_4;
      2'b10: return `TRIG_8;
      default: return `TRIG_14;
    endcase
  endfunction

  always_comb
  begin
    logic en;
    logic mode1;
    logic load_take;
    logic [2:0] ev;
    logic [2:0] clr;
    logic [3:0] src;
    logic irq_any;
    en = 1'b0;
    mode1 = 1'b0;
    load_take = 1'b0;
    ev = 3'h0;
    clr = 3'h0;
    src = `SRC_NONE;
    irq_any = 1'b0;
    s_d = s_q;
    s_d.rdata = 8'h00;
    tx_push = 2'b00;
    tx_pop = 2'b00;
    tx_flush = 2'b00;
    rx_push = 2'b00;
    rx_pop = 2'b00;
    rx_flush = 2'b00;
    limit = '0;
    trig = '0;
    rx_level = 2'b00;
    wr_setup = 2'b00;
    for (int c = 0; c < `CHANNELS; c++)
    begin
      en = s_q.ch[c].setup[`BIT_EN];
      mode1 = en && s_q.ch[c].setup[`BIT_MODE];
      limit[c] = en ? `QUEUE_DEPTH : `SINGLE_DEPTH;
      trig[c] = en ? trig_level(s_q.ch[c].setup[`TRIG_HI:`TRIG_LO]) : `TRIG_1;
      rx_level[c] = rx_count[c] >= trig[c];
      tx_flush[c] = s_q.ch[c].setup[`BIT_TX_FLUSH];
      rx_flush[c] = s_q.ch[c].setup[`BIT_RX_FLUSH];
      s_d.ch[c].setup[`BIT_TX_FLUSH] = 1'b0;
      s_d.ch[c].setup[`BIT_RX_FLUSH] = 1'b0;

      wr_setup[c] = bus_in.wr && hit(bus_in.addr, c, `REG_SETUP);
      if (wr_setup[c])
      begin
        if (bus_in.wdata[`BIT_EN])
        begin
          s_d.ch[c].setup = bus_in.wdata & `SETUP_KEEP;
        end
        else
        begin
          // Only the enable bit follows a write with bit 0 clear.
          s_d.ch[c].setup[`BIT_EN] = 1'b0;
        end
      end

      tx_push[c] = bus_in.wr && hit(bus_in.addr, c, `REG_DATA);
      // The stage feeds the transmit shift path and survives a flush.
      load_take = shift_in[c].tx_load && s_q.ch[c].stage_valid;
      tx_pop[c] = (!s_q.ch[c].stage_valid || load_take) && !tx_empty[c];
      if (load_take)
      begin
        s_d.ch[c].stage_valid = 1'b0;
      end
      if (tx_pop[c])
      begin
        s_d.ch[c].stage_valid = 1'b1;
        s_d.ch[c].stage_data = tx_head[c];
      end

      rx_push[c] = shift_in[c].rx_valid;

      if (bus_in.rd)
      begin
        if (hit(bus_in.addr, c, `REG_DATA))
        begin
          s_d.rdata = rx_head[c];
          rx_pop[c] = !rx_empty[c];
        end
        if (hit(bus_in.addr, c, `REG_SETUP))
        begin
          s_d.rdata = s_q.ch[c].setup;
        end
        if (hit(bus_in.addr, c, `REG_SOURCE))
        begin
          if (rx_level[c])
          begin
            src = `SRC_RX;
          end
          else if (s_q.ch[c].status[`EV_RX_TMO])
          begin
            src = `SRC_RX_TMO;
          end
          else if (tx_empty[c])
          begin
            src = `SRC_TX;
          end
          else
          begin
            src = `SRC_NONE;
          end
          s_d.rdata = {en, en, 2'b00, src};
        end
        if (hit(bus_in.addr, c, `REG_STATUS))
        begin
          s_d.rdata = {5'h00, s_q.ch[c].status};
        end
        if (hit(bus_in.addr, c, `REG_MASK))
        begin
          s_d.rdata = {5'h00, s_q.ch[c].mask};
        end
      end

      ev = 3'h0;
      ev[`EV_RX_LEVEL] = rx_level[c] && !s_q.ch[c].rx_level;
      ev[`EV_TX_EMPTY] = tx_empty[c] && !s_q.ch[c].tx_empty;
      ev[`EV_RX_TMO] = shift_in[c].rx_timeout;
      s_d.ch[c].rx_level = rx_level[c];
      s_d.ch[c].tx_empty = tx_empty[c];
      clr = 3'h0;
      if (bus_in.wr && hit(bus_in.addr, c, `REG_STATUS))
      begin
        clr = bus_in.wdata[2:0];
      end
      // A new event in the clearing cycle keeps its bit set.
      s_d.ch[c].status = (s_q.ch[c].status & ~clr) | ev;
      if (bus_in.wr && hit(bus_in.addr, c, `REG_MASK))
      begin
        s_d.ch[c].mask = bus_in.wdata[2:0];
      end
      irq_any = irq_any || ((s_d.ch[c].status & s_d.ch[c].mask) != 3'h0);

      if (mode1)
      begin
        s_d.ch[c].tx_req_n = tx_full[c];
        if (rx_level[c] || shift_in[c].rx_timeout)
        begin
          s_d.ch[c].rx_req_n = 1'b0;
        end
        else if (rx_empty[c])
        begin
          s_d.ch[c].rx_req_n = 1'b1;
        end
      end
      else
      begin
        s_d.ch[c].tx_req_n = !tx_empty[c];
        s_d.ch[c].rx_req_n = rx_empty[c];
      end
    end
    s_d.irq = irq_any;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      s_q <= '0;
      for (int c = 0; c < `CHANNELS; c++)
      begin
        s_q.ch[c].setup <= `SETUP_RESET;
        s_q.ch[c].rx_req_n <= 1'b1;
        s_q.ch[c].tx_empty <= 1'b1;
      end
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign rdata_out = s_q.rdata;
  assign irq_out = s_q.irq;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  for (genvar g = 0; g < `CHANNELS; g++)
  begin : g_chan
    fifo_queue u_tx (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .flush_in(tx_flush[g]),
      .limit_in(limit[g]),
      .push_in(tx_push[g]),
      .data_in(bus_in.wdata),
      .pop_in(tx_pop[g]),
      .data_out(tx_head[g]),
      .count_out(tx_count[g]),
      .full_out(tx_full[g]),
      .empty_out(tx_empty[g])
    );
    fifo_queue u_rx (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .flush_in(rx_flush[g]),
      .limit_in(limit[g]),
      .push_in(rx_push[g]),
      .data_in(shift_in[g].rx_data),
      .pop_in(rx_pop[g]),
      .data_out(rx_head[g]),
      .count_out(rx_count[g]),
      .full_out(rx_full[g]),
      .empty_out(rx_empty[g])
    );
    assign shift_out[g].tx_valid = s_q.ch[g].stage_valid;
    assign shift_out[g].tx_data = s_q.ch[g].stage_data;
    assign tx_dma_request_n_out[g] = s_q.ch[g].tx_req_n;
    assign rx_dma_request_n_out[g] = s_q.ch[g].rx_req_n;

    property p_trig_fourteen;
      s_q.ch[g].setup[0] && s_q.ch[g].setup[7:6] == 2'b11 && rx_count[g] == 5'h0d
        |-> !rx_level[g];
    endproperty
    a_trig_fourteen: assert property (p_trig_fourteen)
      else $error("level 14 raised at 13 characters");

    property p_rx_event;
      $rose(rx_level[g]) |=> s_q.ch[g].status[0];
    endproperty
    a_rx_event: assert property (p_rx_event)
      else $error("threshold reach did not set status");

    property p_keep_filling;
      s_q.ch[g].setup[0] && rx_push[g] && !rx_pop[g] && !rx_flush[g]
        && rx_level[g] && rx_count[g] < 5'h10
        |=> rx_count[g] == $past(rx_count[g]) + 5'h01;
    endproperty
    a_keep_filling: assert property (p_keep_filling)
      else $error("receive queue refused below full");

    property p_unused_zero;
      s_q.ch[g].setup[5:4] == 2'b00;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
      else $error("unused setup bits not zero");

    property p_tx_mode0;
      (!s_q.ch[g].setup[0] || !s_q.ch[g].setup[3]) && tx_count[g] == 5'h00
        |=> !tx_dma_request_n_out[g];
    endproperty
    a_tx_mode0: assert property (p_tx_mode0)
      else $error("transmit ready not low when empty");

    property p_tx_mode1;
      s_q.ch[g].setup[0] && s_q.ch[g].setup[3] && tx_count[g] != 5'h10
        |=> !tx_dma_request_n_out[g];
    endproperty
    a_tx_mode1: assert property (p_tx_mode1)
      else $error("transmit ready high with room free");

    property p_rx_mode0;
      !(s_q.ch[g].setup[0] && s_q.ch[g].setup[3]) && rx_count[g] != 5'h00
        |=> !rx_dma_request_n_out[g];
    endproperty
    a_rx_mode0: assert property (p_rx_mode0)
      else $error("receive ready not low with data held");

    property p_rx_timeout;
      s_q.ch[g].setup[0] && s_q.ch[g].setup[3] && shift_in[g].rx_timeout
        |=> !rx_dma_request_n_out[g] && s_q.ch[g].status[2];
    endproperty
    a_rx_timeout: assert property (p_rx_timeout)
      else $error("timeout did not assert receive ready");

    sequence s_tx_flush_wr;
      wr_setup[g] && bus_in.wdata[0] && bus_in.wdata[2];
    endsequence
    sequence s_tx_flushed;
      tx_flush[g] ##1 (tx_count[g] == 5'h00 && (!tx_flush[g] || $past(wr_setup[g])));
    endsequence
    property p_tx_flush;
      s_tx_flush_wr |=> s_tx_flushed;
    endproperty
    a_tx_flush: assert property (p_tx_flush)
      else $error("transmit flush failed or did not clear");

    sequence s_rx_flush_wr;
      wr_setup[g] && bus_in.wdata[0] && bus_in.wdata[1];
    endsequence
    property p_rx_flush;
      s_rx_flush_wr |=> rx_flush[g] ##1 (rx_count[g] <= 5'h01);
    endproperty
    a_rx_flush: assert property (p_rx_flush)
      else $error("receive flush failed");

    property p_locked;
      wr_setup[g] && !bus_in.wdata[0]
        |=> s_q.ch[g].setup[7:3] == $past(s_q.ch[g].setup[7:3]) && !s_q.ch[g].setup[0];
    endproperty
    a_locked: assert property (p_locked)
      else $error("setup changed by write with bit 0 clear");

    property p_source_bits;
      bus_in.rd && hit(bus_in.addr, g, `REG_SOURCE)
        |=> rdata_out[7:6] == {2{$past(s_q.ch[g].setup[0])}};
    endproperty
    a_source_bits: assert property (p_source_bits)
      else $error("source bits 7:6 wrong");
  end
endmodule // uart_fifo_control_dma_ready

//--- uart_shift_model.sv
// Behavioural model of the transmit and receive shift paths of both channels.
`timescale 1ns/1ps
module uart_shift_model (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire uart_fifo_pkg::shift_out_type [1:0] tx_path_in,
  input wire logic [1:0] drain_in,
  input wire logic [1:0] push_in,
  input wire logic [7:0] byte_in,
  input wire logic [1:0] tmo_in,
  output uart_fifo_pkg::shift_in_type [1:0] shift_out,
  output logic [1:0][7:0] last_tx_out
);
  logic [1:0] rxv_q;
  logic [1:0] tmo_q;
  logic [1:0][7:0] rxd_q;

  always_ff @(posedge clk_sys_in)
  begin
    for (int c = 0; c < 2; c++)
    begin
      rxv_q[c] <= push_in[c] & ~rst_in;
      tmo_q[c] <= tmo_in[c] & ~rst_in;
      // Between characters the data lines toggle every cycle between the last byte and its inverse, never a held value.
      if (rst_in)
        rxd_q[c] <= 8'h5a;
      else
        rxd_q[c] <= push_in[c] ? byte_in : ~rxd_q[c];
      if (rst_in)
        last_tx_out[c] <= 8'h00;
      else if (shift_out[c].tx_load)
        last_tx_out[c] <= tx_path_in[c].tx_data;
    end
  end

  // The transmitter takes a waiting byte at once unless the bench holds it stalled.
  always_comb
  begin
    for (int c = 0; c < 2; c++)
      shift_out[c] = '{rx_valid: rxv_q[c], rx_data: rxd_q[c], rx_timeout: tmo_q[c],
                       tx_load: drain_in[c] & tx_path_in[c].tx_valid};
  end
endmodule // uart_shift_model

//--- uart_fifo_control_dma_ready_tb.sv
// Self-checking testbench for the UART FIFO control and DMA ready block.
`timescale 1ns/1ps
module uart_fifo_control_dma_ready_tb;
  localparam int cycle_limit = 20000;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  uart_fifo_pkg::bus_req_type bus_q = '0;
  uart_fifo_pkg::shift_in_type [1:0] sh_in;
  uart_fifo_pkg::shift_out_type [1:0] sh_out;
  logic [7:0] rdata;
  logic [1:0] tx_n;
  logic [1:0] rx_n;
  logic irq;
  logic [1:0] drain_q = '0;
  logic [1:0] push_q = '0;
  logic [1:0] tmo_q = '0;
  logic [7:0] byte_q = '0;
  logic [7:0] rd_q;
  logic [1:0][7:0] last_tx;
  logic [4:0] trig [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;

  always #2 clk_sys_in = ~clk_sys_in;

  uart_fifo_control_dma_ready i_uart_fifo_control_dma_ready (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus_in(bus_q), .rdata_out(rdata),
    .shift_in(sh_in), .shift_out(sh_out), .tx_dma_request_n_out(tx_n),
    .rx_dma_request_n_out(rx_n), .irq_out(irq));

  uart_shift_model i_uart_shift_model (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .tx_path_in(sh_out), .drain_in(drain_q),
    .push_in(push_q), .byte_in(byte_q), .tmo_in(tmo_q), .shift_out(sh_in),
    .last_tx_out(last_tx));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    bus_q <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_in);
    bus_q.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys_in);
    bus_q <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_in);
    bus_q.rd <= 1'b0;
    #1 rd_q = rdata;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string what);
    rd(a);
    chk(rd_q, exp, what);
  endtask

  task automatic push(input int c, input logic [7:0] d);
    @(posedge clk_sys_in);
    push_q[c] <= 1'b1;
    byte_q <= d;
    @(posedge clk_sys_in);
    push_q[c] <= 1'b0;
    // The byte reaches the queue one edge after the model strobes it.
    @(posedge clk_sys_in);
  endtask

  // Ready outputs lag the queues, so let them settle before looking.
  task automatic pins(input int c, input logic [1:0] exp, input string what);
    repeat (3) @(posedge clk_sys_in);
    #1 chk({tx_n[c], rx_n[c]}, exp, what);
  endtask

  task automatic irq_is(input logic exp, input string what);
    repeat (3) @(posedge clk_sys_in);
    #1 chk(irq, exp, what);
  endtask

  always @(posedge clk_sys_in)
  begin
    cycles <= cycles + 1;
    if (cycles == cycle_limit)
    begin
      n_errors++;
      complete_run();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rchk(4'h1, 8'h00, "setup after reset");
    rchk(4'h2, 8'h02, "source after reset");
    pins(0, 2'b01, "ready after reset");
    rchk(4'h5, 8'h00, "unmapped read");
    wr(4'h1, 8'hf9);
    rchk(4'h1, 8'hc9, "setup fields");
    rd(4'h2);
    chk(rd_q & 8'hc0, 8'hc0, "enabled in source");
    wr(4'h1, 8'h46);
    rchk(4'h1, 8'hc8, "write without enable");
    rd(4'h2);
    chk(rd_q & 8'hc0, 8'h00, "disabled in source");
    rchk(4'h9, 8'h00, "other channel untouched");
    $display("test register fields done");
    for (int s = 0; s < 4; s++)
    begin
      int n;
      n = (s == 3) ? 16 : int'(trig[s]);
      wr(4'h1, {s[1:0], 6'h03});
      rchk(4'h1, {s[1:0], 6'h01}, "flush bits clear");
      wr(4'h3, 8'h07);
      for (int k = 1; k <= n; k++)
      begin
        push(0, 8'(k));
        if (k == trig[s] - 1 || k == trig[s])
        begin
          rd(4'h3);
          chk(rd_q[0], k == trig[s], "level event");
        end
        if (k == trig[s])
          rchk(4'h2, 8'hc4, "level source");
      end
      if (s == 3)
        push(0, 8'hee);
      pins(0, 2'b00, "rx held");
      for (int k = 1; k <= n; k++)
      begin
        rchk(4'h0, 8'(k), "rx order");
        if (n - k == trig[s] - 1)
        begin
          rd(4'h2);
          chk(rd_q[3:0] == 4'h4, 1'b0, "level withdrawn");
        end
      end
      pins(0, 2'b01, "rx drained");
    end
    $display("test trigger levels done");
    push(0, 8'h01);
    wr(4'h1, 8'h4b);
    pins(0, 2'b01, "rx flushed");
    for (int k = 1; k < 5; k++)
    begin
      push(0, 8'(k));
      pins(0, {1'b0, k < 4}, "block rx level");
    end
    for (int k = 1; k < 5; k++)
    begin
      rd(4'h0);
      pins(0, {1'b0, k == 4}, "block rx hold");
    end
    push(0, 8'h09);
    pins(0, 2'b01, "below level");
    @(posedge clk_sys_in);
    tmo_q[0] <= 1'b1;
    @(posedge clk_sys_in);
    tmo_q[0] <= 1'b0;
    pins(0, 2'b00, "block rx timeout");
    rd(4'h0);
    pins(0, 2'b01, "timeout drained");
    $display("test block receive done");
    for (int k = 1; k < 18; k++)
    begin
      wr(4'h0, 8'h80 + 8'(k));
      if (k > 15)
        pins(0, {k == 17, 1'b1}, "block tx full");
    end
    wr(4'h1, 8'h4d);
    pins(0, 2'b01, "tx flushed");
    rchk(4'h1, 8'h49, "tx flush clear");
    @(posedge clk_sys_in);
    drain_q[0] <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    #1 chk({sh_out[0].tx_valid, last_tx[0]}, 9'h081, "stage kept");
    $display("test block transmit done");
    @(posedge clk_sys_in);
    drain_q[0] <= 1'b0;
    wr(4'h1, 8'h06);
    rchk(4'h1, 8'h48, "only enable clears");
    wr(4'h0, 8'h55);
    pins(0, 2'b01, "stage takes byte");
    wr(4'h0, 8'h66);
    pins(0, 2'b11, "tx held");
    push(0, 8'h11);
    push(0, 8'h22);
    rchk(4'h0, 8'h11, "single buffer");
    pins(0, 2'b11, "second dropped");
    $display("test single buffer done");
    wr(4'h4, 8'h00);
    wr(4'h3, 8'h07);
    wr(4'h9, 8'h01);
    wr(4'hc, 8'h00);
    wr(4'hb, 8'h07);
    push(1, 8'h33);
    pins(1, 2'b00, "second channel rx");
    pins(0, 2'b11, "first channel apart");
    irq_is(1'b0, "masked event");
    wr(4'hc, 8'h01);
    irq_is(1'b1, "unmasked event");
    wr(4'hb, 8'h01);
    irq_is(1'b0, "event cleared");
    rchk(4'h9, 8'h01, "second setup");
    rchk(4'h1, 8'h48, "first setup kept");
    $display("test channels and interrupt done");
    complete_run();
  end
endmodule // uart_fifo_control_dma_ready_tb
